// [rtl/dmu_pkg.sv]
// Shared constants and types for the multiply and dot-product unit
package dmu_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_MUL_UBYTE_UHALF_SAT_LEFT,
        OP_MUL_UBYTE_UHALF_SAT_RIGHT,
        OP_MUL_FRAC_PAIR_ROUND_SAT,
        OP_MUL_FRAC_TO_WORD_LEFT,
        OP_MUL_FRAC_TO_WORD_RIGHT,
        OP_DOT_ADD_UBYTE_LEFT,
        OP_DOT_ADD_UBYTE_RIGHT,
        OP_DOT_SUB_UBYTE_LEFT,
        OP_DOT_SUB_UBYTE_RIGHT,
        OP_DOT_ADD_SHALF,
        OP_DOT_ADD_SHALF_CROSSED
    } dmu_op_t;

    // ------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------
    localparam logic [15:0] MINUS_ONE_Q15 = 16'h8000;     // -1.0 in Q15
    localparam logic [15:0] MAX_Q15       = 16'h7FFF;     // Largest positive Q15
    localparam logic [31:0] MAX_Q31       = 32'h7FFFFFFF; // Largest positive Q31
    localparam logic [31:0] ROUND_CONST   = 32'h00008000; // Rounding addend
    localparam logic [15:0] UHALF_MAX     = 16'hFFFF;     // Unsigned halfword ceiling

    // ------------------------------------------------------------
    // Reset values of the result stage
    // ------------------------------------------------------------
    localparam logic [31:0] RST_GPR_DATA  = 32'h00000000;
    localparam logic [63:0] RST_ACC_DATA  = 64'h0000000000000000;
    localparam logic [1:0]  RST_ACC_IDX   = 2'h0;

endpackage

// [rtl/dmu_lane_if.sv]
// Operand and product bundle between the unit and one multiplier lane
`timescale 1ns/1ps
interface dmu_lane_if;
    logic [15:0] a;        // First factor (byte ops use low 8 bits)
    logic [15:0] b;        // Second factor
    logic [15:0] uh_sat;   // Byte x halfword, clamped to 16 bits
    logic [15:0] q15;      // Rounded Q15 product
    logic [31:0] q31;      // Doubled Q31 product
    logic [15:0] ub_prod;  // Byte x byte product
    logic [31:0] s_prod;   // Signed integer product

    // Unit side drives factors
    modport top  (output a, b, input uh_sat, q15, q31, ub_prod, s_prod);
    // Lane side drives products
    modport lane (input a, b, output uh_sat, q15, q31, ub_prod, s_prod);
endinterface

// [rtl/dmu_lane.sv]
// One multiplier lane: all product forms of a pair of factors
`timescale 1ns/1ps
module dmu_lane
    import dmu_pkg::*;
(
    // Factors in, products out
    dmu_lane_if.lane bus
);

    // ------------------------------------------------------------
    // Products
    // ------------------------------------------------------------
    logic [23:0]        uxh;     // Unsigned byte x unsigned halfword
    logic signed [31:0] sp;      // Signed halfword product
    logic               both_m1; // Both factors are -1.0
    logic [31:0]        rnd;     // Doubled product plus rounding

    always_comb begin
        uxh     = {16'h0000, bus.a[7:0]} * {8'h00, bus.b};
        sp      = $signed(bus.a) * $signed(bus.b);
        both_m1 = (bus.a == MINUS_ONE_Q15) && (bus.b == MINUS_ONE_Q15);
        // Clamp to all ones when the 24-bit product needs more than 16 bits
        // clamp to ones
        bus.uh_sat  = (uxh > {8'h00, UHALF_MAX}) ? UHALF_MAX : uxh[15:0];
        // Doubling makes Q31; only -1.0 x -1.0 overflows
        // double, saturate
        bus.q31     = both_m1 ? MAX_Q31 : {sp[30:0], 1'b0};
        rnd         = bus.q31 + ROUND_CONST;
        bus.q15     = both_m1 ? MAX_Q15 : rnd[31:16];
        bus.ub_prod = {8'h00, bus.a[7:0]} * {8'h00, bus.b[7:0]};
        bus.s_prod  = sp;
    end

endmodule

// [rtl/dmu_unit.sv]
// Multiply and dot-product datapath with one registered result stage
//
// Functional notes
// - Multiply byte elements by halfword elements elementwise
// - Clamp byte-halfword products above 0xFFFF to ones
// - Pair multiply adds 0x00008000, keeps upper half
// - Pair multiply: -1.0 times -1.0 gives max Q15
// - Fractional multiplies never write extra accumulators
// - Word multiply doubles the product into Q31
// - Word multiply: -1.0 times -1.0 gives max Q31
// - Unsigned byte dot product added to accumulator
// - Unsigned byte dot product subtracted from accumulator
// - Signed halfword dot product added to accumulator
// - Crossed halfword dot product added to accumulator
`timescale 1ns/1ps
module dmu_unit
    import dmu_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Decoded operation from the pipeline
    input  wire logic        op_valid,
    input  wire dmu_op_t     op,
    input  wire logic [31:0] src_s,
    input  wire logic [31:0] src_t,
    input  wire logic [1:0]  accumulator_select,
    input  wire logic [63:0] acc_in,
    // General register result
    output logic             gpr_wr,
    output logic [31:0]      gpr_data,
    // Accumulator result
    output logic             acc_wr,
    output logic [1:0]       acc_idx,
    output logic [63:0]      acc_data
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        gpr_wr;   // General register write strobe
        logic [31:0] gpr_data; // General register value
        logic        acc_wr;   // Accumulator write strobe
        logic [1:0]  acc_idx;  // Target accumulator
        logic [63:0] acc_data; // New accumulator value
    } dmu_state_t;

    dmu_state_t state;        // Registered result
    dmu_state_t next_state;   // Next result

    logic [63:0] dsum;        // Dot-product sum at 64 bits (halfword products sign-extended, byte products zero-extended)

    // ------------------------------------------------------------
    // Multiplier lanes (0 = upper element, 1 = lower element)
    // ------------------------------------------------------------
    dmu_lane_if lane_bus [2] ();

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            dmu_lane u_dmu_lane (
                .bus (lane_bus[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Operand steering
    // ------------------------------------------------------------
    always_comb begin
        // Default pairing: upper with upper, lower with lower
        lane_bus[0].a = src_s[31:16];
        lane_bus[0].b = src_t[31:16];
        lane_bus[1].a = src_s[15:0];
        lane_bus[1].b = src_t[15:0];
        unique case (op)
            OP_MUL_UBYTE_UHALF_SAT_LEFT: begin
                lane_bus[0].a = {8'h00, src_s[31:24]};
                lane_bus[1].a = {8'h00, src_s[23:16]};
            end
            OP_MUL_UBYTE_UHALF_SAT_RIGHT: begin
                lane_bus[0].a = {8'h00, src_s[15:8]};
                lane_bus[1].a = {8'h00, src_s[7:0]};
            end
            OP_DOT_ADD_UBYTE_LEFT, OP_DOT_SUB_UBYTE_LEFT: begin
                lane_bus[0].a = {8'h00, src_s[31:24]};
                lane_bus[0].b = {8'h00, src_t[31:24]};
                lane_bus[1].a = {8'h00, src_s[23:16]};
                lane_bus[1].b = {8'h00, src_t[23:16]};
            end
            OP_DOT_ADD_UBYTE_RIGHT, OP_DOT_SUB_UBYTE_RIGHT: begin
                lane_bus[0].a = {8'h00, src_s[15:8]};
                lane_bus[0].b = {8'h00, src_t[15:8]};
                lane_bus[1].a = {8'h00, src_s[7:0]};
                lane_bus[1].b = {8'h00, src_t[7:0]};
            end
            OP_DOT_ADD_SHALF_CROSSED: begin
                lane_bus[0].b = src_t[15:0];
                lane_bus[1].b = src_t[31:16];
            end
            // Default pairing serves the rest
            default: begin
            end
        endcase
    end

    // ------------------------------------------------------------
    // Result formation
    // ------------------------------------------------------------
    always_comb begin
        // widen the products to accumulator width: sign-extend halfword products, zero-extend byte products
        if (op == OP_DOT_ADD_SHALF || op == OP_DOT_ADD_SHALF_CROSSED) begin
            dsum = {{32{lane_bus[0].s_prod[31]}}, lane_bus[0].s_prod}
                 + {{32{lane_bus[1].s_prod[31]}}, lane_bus[1].s_prod};
        end else begin
            dsum = {48'h000000000000, lane_bus[0].ub_prod} + {48'h000000000000, lane_bus[1].ub_prod};
        end
        next_state          = state;
        next_state.gpr_wr   = 1'b0;
        next_state.acc_wr   = 1'b0;
        if (op_valid) begin
            unique case (op)
                OP_MUL_UBYTE_UHALF_SAT_LEFT, OP_MUL_UBYTE_UHALF_SAT_RIGHT: begin
                    next_state.gpr_wr   = 1'b1;
                    next_state.gpr_data = {lane_bus[0].uh_sat, lane_bus[1].uh_sat};
                end
                OP_MUL_FRAC_PAIR_ROUND_SAT: begin
                    next_state.gpr_wr   = 1'b1;
                    next_state.gpr_data = {lane_bus[0].q15, lane_bus[1].q15};
                end
                OP_MUL_FRAC_TO_WORD_LEFT: begin
                    next_state.gpr_wr   = 1'b1;
                    next_state.gpr_data = lane_bus[0].q31;
                end
                OP_MUL_FRAC_TO_WORD_RIGHT: begin
                    next_state.gpr_wr   = 1'b1;
                    next_state.gpr_data = lane_bus[1].q31;
                end
                OP_DOT_ADD_UBYTE_LEFT, OP_DOT_ADD_UBYTE_RIGHT,
                OP_DOT_ADD_SHALF, OP_DOT_ADD_SHALF_CROSSED: begin
                    next_state.acc_wr   = 1'b1;
                    next_state.acc_idx  = accumulator_select;
                    next_state.acc_data = acc_in + dsum;
                end
                OP_DOT_SUB_UBYTE_LEFT, OP_DOT_SUB_UBYTE_RIGHT: begin
                    next_state.acc_wr   = 1'b1;
                    next_state.acc_idx  = accumulator_select;
                    next_state.acc_data = acc_in - dsum;
                end
                // No operation: nothing written
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '{gpr_wr: 1'b0, gpr_data: RST_GPR_DATA, acc_wr: 1'b0,
                       acc_idx: RST_ACC_IDX, acc_data: RST_ACC_DATA};
        end else begin
            state <= next_state;
        end
    end

    assign gpr_wr   = state.gpr_wr;
    assign gpr_data = state.gpr_data;
    assign acc_wr   = state.acc_wr;
    assign acc_idx  = state.acc_idx;
    assign acc_data = state.acc_data;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic signed [31:0] chk_hh;   // Upper halfword product
    logic [31:0]        chk_q31;  // Doubled upper product
    logic [31:0]        chk_rnd;  // Rounded upper product
    logic               chk_m1;   // Upper factors both -1.0
    logic [23:0]        chk_uhl;  // Left byte x halfword, upper lane
    logic [23:0]        chk_uhr;  // Right byte x halfword, upper lane
    logic [63:0]        chk_ubl;  // Left unsigned byte dot sum
    logic [63:0]        chk_sh;   // Straight halfword dot sum
    logic [63:0]        chk_x;    // Crossed halfword dot sum
    logic               chk_frac; // Fractional multiply in flight

    always_comb begin
        chk_hh   = $signed(src_s[31:16]) * $signed(src_t[31:16]);
        chk_q31  = {chk_hh[30:0], 1'b0};
        chk_rnd  = chk_q31 + ROUND_CONST;
        chk_m1   = (src_s[31:16] == MINUS_ONE_Q15) && (src_t[31:16] == MINUS_ONE_Q15);
        chk_uhl  = {16'h0000, src_s[31:24]} * {8'h00, src_t[31:16]};
        chk_uhr  = {16'h0000, src_s[15:8]} * {8'h00, src_t[31:16]};
        chk_ubl  = {56'h00000000000000, src_s[31:24]} * {56'h00000000000000, src_t[31:24]}
                 + {56'h00000000000000, src_s[23:16]} * {56'h00000000000000, src_t[23:16]};
        // Factors widened first so the products keep all 32 bits
        chk_sh   = 64'(32'($signed(src_s[31:16])) * 32'($signed(src_t[31:16])))
                 + 64'(32'($signed(src_s[15:0])) * 32'($signed(src_t[15:0])));
        chk_x    = 64'(32'($signed(src_s[31:16])) * 32'($signed(src_t[15:0])))
                 + 64'(32'($signed(src_s[15:0])) * 32'($signed(src_t[31:16])));
        chk_frac = (op == OP_MUL_FRAC_PAIR_ROUND_SAT) || (op == OP_MUL_FRAC_TO_WORD_LEFT)
                || (op == OP_MUL_FRAC_TO_WORD_RIGHT);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    uh_clamp_a: assert property (op_valid && op == OP_MUL_UBYTE_UHALF_SAT_LEFT |=> gpr_wr &&
        gpr_data[31:16] == ($past(chk_uhl) > 24'h00FFFF ? UHALF_MAX : $past(chk_uhl[15:0])))
        else $error("byte-halfword clamp wrong");
    uh_right_a: assert property (op_valid && op == OP_MUL_UBYTE_UHALF_SAT_RIGHT |=>
        gpr_data[31:16] == ($past(chk_uhr) > 24'h00FFFF ? UHALF_MAX : $past(chk_uhr[15:0])))
        else $error("right variant picked wrong bytes");
    pair_round_a: assert property (op_valid && op == OP_MUL_FRAC_PAIR_ROUND_SAT && !chk_m1 |=>
        gpr_wr && gpr_data[31:16] == $past(chk_rnd[31:16]))
        else $error("Q15 rounding wrong");
    pair_sat_a: assert property (op_valid && op == OP_MUL_FRAC_PAIR_ROUND_SAT && chk_m1 |=>
        gpr_data[31:16] == MAX_Q15)
        else $error("Q15 saturation missing");
    frac_no_acc_a: assert property (op_valid && chk_frac |=> !acc_wr && gpr_wr)
        else $error("fractional multiply wrote accumulator");
    word_shift_a: assert property (op_valid && op == OP_MUL_FRAC_TO_WORD_LEFT && !chk_m1 |=>
        gpr_data == $past(chk_q31))
        else $error("Q31 doubling wrong");
    word_sat_a: assert property (op_valid && op == OP_MUL_FRAC_TO_WORD_LEFT && chk_m1 |=>
        gpr_data == MAX_Q31)
        else $error("Q31 saturation missing");
    dot_ubyte_a: assert property (op_valid && op == OP_DOT_ADD_UBYTE_LEFT |=> acc_wr &&
        acc_idx == $past(accumulator_select) && acc_data == $past(acc_in) + $past(chk_ubl))
        else $error("byte dot add wrong");
    dot_sub_a: assert property (op_valid && op == OP_DOT_SUB_UBYTE_LEFT |=> acc_wr &&
        acc_data == $past(acc_in) - $past(chk_ubl))
        else $error("byte dot subtract wrong");
    dot_shalf_a: assert property (op_valid && op == OP_DOT_ADD_SHALF |=> acc_wr &&
        acc_data == $past(acc_in) + $past(chk_sh))
        else $error("halfword dot add wrong");
    dot_cross_a: assert property (op_valid && op == OP_DOT_ADD_SHALF_CROSSED |=>
        acc_data == $past(acc_in) + $past(chk_x))
        else $error("crossed dot add wrong");
    // Subtracting from an empty accumulator must go negative, not stick at zero
    acc_wrap_a: assert property (op_valid && op == OP_DOT_SUB_UBYTE_LEFT && acc_in == 64'h0000000000000000
        && chk_ubl != 64'h0000000000000000 |=> acc_data[63] == 1'b1)
        else $error("accumulator did not wrap");

    sat_seen_c:   cover property (op_valid && op == OP_MUL_UBYTE_UHALF_SAT_LEFT && chk_uhl > 24'h00FFFF);
    q15_sat_c:    cover property (op_valid && op == OP_MUL_FRAC_PAIR_ROUND_SAT && chk_m1);
    dot_back_c:   cover property (op_valid && op == OP_DOT_ADD_SHALF ##1 op_valid && op == OP_DOT_ADD_SHALF_CROSSED);

endmodule

// [tb/dmu_pipe_model.sv]
// Pipeline model: accumulator file with write-back and forwarding
`timescale 1ns/1ps
module dmu_pipe_model
    import dmu_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Operand request
    input  wire logic [1:0]  accumulator_select,
    output logic [63:0]      acc_in,
    // Accumulator write-back
    input  wire logic        acc_wr,
    input  wire logic [1:0]  acc_idx,
    input  wire logic [63:0] acc_data
);
    logic [63:0] acc_file [4];   // Architectural accumulators

    // Forward a write landing now, since the unit has no forwarding of its own
    always_comb begin
        if (acc_wr && acc_idx == accumulator_select) begin
            acc_in = acc_data;
        end else begin
            acc_in = acc_file[accumulator_select];
        end
    end

    // Write back the unit's accumulator result
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int k = 0; k < 4; k++) begin
                acc_file[k] <= RST_ACC_DATA;
            end
        end else if (acc_wr) begin
            acc_file[acc_idx] <= acc_data;
        end
    end
endmodule

// [tb/dsp_multiply_dot_product_unit_test.sv]
// Self-checking bench for the multiply and dot-product unit
`timescale 1ns/1ps
module dsp_multiply_dot_product_unit_test
    import dmu_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk;                  // Core clock
    logic        resetn;               // Synchronous reset, active low
    logic        op_valid;             // Operation present
    dmu_op_t     op;                   // Decoded operation
    logic [31:0] src_s;                // First source
    logic [31:0] src_t;                // Second source
    logic [1:0]  accumulator_select;   // Target accumulator
    logic [63:0] acc_in;               // Selected accumulator from the model
    logic        gpr_wr;               // Register result strobe
    logic [31:0] gpr_data;             // Register result
    logic        acc_wr;               // Accumulator strobe
    logic [1:0]  acc_idx;              // Accumulator written
    logic [63:0] acc_data;             // Accumulator value
    logic [63:0] exp_acc [4];          // Expected accumulators
    int          n_errors;             // Mismatches
    int          checks;               // Comparisons

    dmu_unit u_dmu_unit (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op(op), .src_s(src_s),
        .src_t(src_t), .accumulator_select(accumulator_select), .acc_in(acc_in), .gpr_wr(gpr_wr),
        .gpr_data(gpr_data), .acc_wr(acc_wr), .acc_idx(acc_idx), .acc_data(acc_data));
    dmu_pipe_model u_dmu_pipe_model (.clk(clk), .resetn(resetn), .accumulator_select(accumulator_select),
        .acc_in(acc_in), .acc_wr(acc_wr), .acc_idx(acc_idx), .acc_data(acc_data));

    // ------------------------------------------------------------
    // Reference arithmetic
    // ------------------------------------------------------------
    function automatic logic [15:0] sat_uh(logic [7:0] b, logic [15:0] h);
        logic [23:0] p;
        p = b * h;
        return (p > 24'h00FFFF) ? 16'hFFFF : p[15:0];
    endfunction

    function automatic logic [31:0] dbl_q31(logic [15:0] a, logic [15:0] b);
        logic signed [31:0] p;
        p = 32'($signed(a)) * 32'($signed(b));
        return (a == 16'h8000 && b == 16'h8000) ? 32'h7FFFFFFF : 32'(p <<< 1);
    endfunction

    function automatic logic [15:0] rnd_q15(logic [15:0] a, logic [15:0] b);
        logic [31:0] p;
        p = dbl_q31(a, b) + 32'h00008000;
        return (a == 16'h8000 && b == 16'h8000) ? 16'h7FFF : p[31:16];
    endfunction

    function automatic logic [63:0] ub_sum(logic [15:0] a, logic [15:0] b);
        return 64'h0 + a[15:8] * b[15:8] + a[7:0] * b[7:0];
    endfunction

    // Register result zero-extended, or new accumulator value
    function automatic logic [63:0] expect_val(dmu_op_t o, logic [31:0] s, logic [31:0] t, logic [63:0] acc);
        logic [63:0] sh, sl, th, tl;
        sh = {{48{s[31]}}, s[31:16]};
        sl = {{48{s[15]}}, s[15:0]};
        th = {{48{t[31]}}, t[31:16]};
        tl = {{48{t[15]}}, t[15:0]};
        case (o)
            OP_MUL_UBYTE_UHALF_SAT_LEFT:  return {32'h0, sat_uh(s[31:24], t[31:16]), sat_uh(s[23:16], t[15:0])};
            OP_MUL_UBYTE_UHALF_SAT_RIGHT: return {32'h0, sat_uh(s[15:8], t[31:16]), sat_uh(s[7:0], t[15:0])};
            OP_MUL_FRAC_PAIR_ROUND_SAT:   return {32'h0, rnd_q15(s[31:16], t[31:16]), rnd_q15(s[15:0], t[15:0])};
            OP_MUL_FRAC_TO_WORD_LEFT:     return {32'h0, dbl_q31(s[31:16], t[31:16])};
            OP_MUL_FRAC_TO_WORD_RIGHT:    return {32'h0, dbl_q31(s[15:0], t[15:0])};
            OP_DOT_ADD_UBYTE_LEFT:        return acc + ub_sum(s[31:16], t[31:16]);
            OP_DOT_ADD_UBYTE_RIGHT:       return acc + ub_sum(s[15:0], t[15:0]);
            OP_DOT_SUB_UBYTE_LEFT:        return acc - ub_sum(s[31:16], t[31:16]);
            OP_DOT_SUB_UBYTE_RIGHT:       return acc - ub_sum(s[15:0], t[15:0]);
            OP_DOT_ADD_SHALF:             return acc + sh * th + sl * tl;
            OP_DOT_ADD_SHALF_CROSSED:     return acc + sh * tl + sl * th;
            default:                      return 64'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string name, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Present one op at a falling edge and judge the result one cycle later
    task automatic run_op(dmu_op_t o, logic [31:0] s, logic [31:0] t, logic [1:0] sel = 2'h0);
        logic [63:0] e;
        logic        dot;
        dot = (o >= OP_DOT_ADD_UBYTE_LEFT);
        e = expect_val(o, s, t, exp_acc[sel]);
        op_valid = 1'b1;
        op = o;
        src_s = s;
        src_t = t;
        accumulator_select = sel;
        @(posedge clk);
        @(negedge clk);
        check("gpr_wr", {63'h0, ~dot}, {63'h0, gpr_wr});
        check("acc_wr", {63'h0, dot}, {63'h0, acc_wr});
        if (dot) begin
            check("acc_idx", {62'h0, sel}, {62'h0, acc_idx});
            check("acc_data", e, acc_data);
            exp_acc[sel] = e;
        end else begin
            check("gpr_data", e, {32'h0, gpr_data});
        end
    endtask

    // An idle or empty slot gives no strobe
    task automatic idle(logic v, dmu_op_t o);
        op_valid = v;
        op = o;
        @(posedge clk);
        @(negedge clk);
        check("gpr_wr", 64'h0, {63'h0, gpr_wr});
        check("acc_wr", 64'h0, {63'h0, acc_wr});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("gpr_data", 64'h0, {32'h0, gpr_data});
        check("acc_data", 64'h0, acc_data);
        check("acc_idx", 64'h0, {62'h0, acc_idx});
        idle(1'b0, OP_DOT_ADD_SHALF);
        idle(1'b1, OP_NONE);
    endtask

    task automatic t_ubyte_uhalf();
        run_op(OP_MUL_UBYTE_UHALF_SAT_LEFT, 32'hFF02_1122, 32'h0101_8000);
        run_op(OP_MUL_UBYTE_UHALF_SAT_RIGHT, 32'h9988_03FF, 32'h5555_0102);
        run_op(OP_MUL_UBYTE_UHALF_SAT_RIGHT, 32'hFF02_0101, 32'h00FF_FFFF);
    endtask

    task automatic t_frac();
        run_op(OP_MUL_FRAC_PAIR_ROUND_SAT, 32'h8000_4000, 32'h8000_C000);
        run_op(OP_MUL_FRAC_PAIR_ROUND_SAT, 32'h8000_0001, 32'h7FFF_4000);
        run_op(OP_MUL_FRAC_TO_WORD_LEFT, 32'h8000_1234, 32'h8000_5678);
        run_op(OP_MUL_FRAC_TO_WORD_RIGHT, 32'h8000_1234, 32'h8000_5678);
        run_op(OP_MUL_FRAC_TO_WORD_LEFT, 32'h8000_8000, 32'h7FFF_8000);
        run_op(OP_MUL_FRAC_TO_WORD_RIGHT, 32'h8000_8000, 32'h7FFF_8000);
    endtask

    task automatic t_dot_ubyte();
        run_op(OP_DOT_ADD_UBYTE_LEFT, 32'hFFFF_1234, 32'hFFFF_5678, 2'h2);
        run_op(OP_DOT_SUB_UBYTE_RIGHT, 32'hABCD_FFFF, 32'h1357_FFFF, 2'h2);
        run_op(OP_DOT_SUB_UBYTE_LEFT, 32'h0203_FFFF, 32'h0405_FFFF, 2'h2);
        run_op(OP_DOT_ADD_UBYTE_RIGHT, 32'h7700_0506, 32'h8800_0101, 2'h2);
    endtask

    task automatic t_dot_shalf();
        for (int k = 0; k < 4; k++) begin
            run_op(OP_DOT_ADD_SHALF, 32'h8000_7FFF, 32'h8000_8001, 2'(k));
            run_op(OP_DOT_ADD_SHALF_CROSSED, 32'hFFFE_0003, 32'h0005_8000, 2'(k));
        end
        run_op(OP_DOT_ADD_SHALF, 32'hFFFF_FFFF, 32'h0001_0001, 2'h1);
    endtask

    task automatic t_frac_keeps();
        run_op(OP_MUL_FRAC_PAIR_ROUND_SAT, 32'h1234_5678, 32'h9ABC_DEF0);
        run_op(OP_MUL_FRAC_TO_WORD_LEFT, 32'h1234_5678, 32'h9ABC_DEF0);
        idle(1'b0, OP_NONE);
        for (int k = 0; k < 4; k++) begin
            check("acc_file", exp_acc[k], u_dmu_pipe_model.acc_file[k]);
        end
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        n_errors = 0;
        checks = 0;
        resetn = 1'b0;
        op_valid = 1'b0;
        op = OP_NONE;
        src_s = 32'h0;
        src_t = 32'h0;
        accumulator_select = 2'h0;
        for (int k = 0; k < 4; k++) begin
            exp_acc[k] = 64'h0;
        end
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_ubyte_uhalf();
        t_frac();
        t_dot_ubyte();
        t_dot_shalf();
        t_frac_keeps();
        complete_run();
    end

    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
endmodule
